/* File: pkg/dssc_consts.vh */
`ifndef DSSC_CONSTS_VH
`define DSSC_CONSTS_VH

// Track geometry
`define DSSC_TRACKS 77
`define DSSC_TRK_W 7
`define DSSC_LABEL_TRACK 7'h00
`define DSSC_SPARE_LO 7'h4b
`define DSSC_SPARE_HI 7'h4c
`define DSSC_LAST_TRACK 7'h4c

// Motor geometry: 90 degrees per track, 1.8 degrees per step (tenths of a degree)
`define DSSC_DEG_PER_TRACK_X10 900
`define DSSC_DEG_PER_STEP_X10 18
`define DSSC_STEPS_PER_TRACK 50

// Timing
`define DSSC_CLK_MHZ 200
`define DSSC_TRACK_TIME_US 5000
`define DSSC_SETTLE_TIME_US 35000
`define DSSC_TRACK_CYC (`DSSC_TRACK_TIME_US * `DSSC_CLK_MHZ)
`define DSSC_SETTLE_CYC (`DSSC_SETTLE_TIME_US * `DSSC_CLK_MHZ)
`define DSSC_STEP_CYC (`DSSC_TRACK_CYC / `DSSC_STEPS_PER_TRACK)

// Phase pattern of the four winding halves {b_neg, b_pos, a_neg, a_pos}
`define DSSC_PH0 4'h1
`define DSSC_PH1 4'h4
`define DSSC_PH2 4'h2
`define DSSC_PH3 4'h8

`endif

/* File: logic/dssc_phase_gen.v */
`include "dssc_consts.vh"

module dssc_phase_gen
(
    // Clock and reset
    input wire clk_sys,
    input wire reset,
    // Step request
    input wire step_pulse,
    input wire step_inward,
    // Winding drive, one half of one pair energized
    output reg [3:0] winding_ff
);

reg [1:0] phase_ff;
reg [1:0] nxt_phase;

function [3:0] dssc_pattern;
    input [1:0] ph;
    begin
        case (ph)
            2'h0: dssc_pattern = `DSSC_PH0;
            2'h1: dssc_pattern = `DSSC_PH1;
            2'h2: dssc_pattern = `DSSC_PH2;
            default: dssc_pattern = `DSSC_PH3;
        endcase
    end
endfunction

always @*
begin
    nxt_phase = phase_ff;
    if (step_pulse)
    begin
        // Phase order picks the direction; forward order turns the rotor clockwise (inward)
        if (step_inward)
            nxt_phase = phase_ff + 2'h1;
        else
            nxt_phase = phase_ff - 2'h1;
    end
end

always @(posedge clk_sys)
begin
    if (reset)
    begin
        phase_ff <= 2'h0;
        winding_ff <= `DSSC_PH0;
    end
    else
    begin
        phase_ff <= nxt_phase;
        // Always one half of one pair on, so the rotor stays detented between steps
        winding_ff <= dssc_pattern(nxt_phase);
    end
end

endmodule // dssc_phase_gen

/* File: logic/dssc_seek_ctrl.v */
// Summary of operation
// - Address 77 tracks per side, track 00 outermost, numbers rising toward hub.
// - Track 00 is the label track; data accesses to it are refused.
// - Tracks 75 and 76 take data only as substitutes for damaged tracks.
// - A single-sided medium blocks every read or write to side two.
// - Both sides at one carriage position form a cylinder, reachable without stepping.
// - Direction of travel is set by the order windings are energized.
// - Only one half of each winding pair is energized at a time.
// - One track is 90 degrees of rotation, 1.8 degrees per step pulse.
// - Clockwise steps move inward to higher tracks; reverse order moves outward.
// - Each track takes 5 ms; 35 ms settling follows the last track.
// - Windings stay energized between steps to hold the rotor detent.
`include "dssc_consts.vh"

module dssc_seek_ctrl
#(
    parameter STEP_CYC = `DSSC_STEP_CYC,
    parameter SETTLE_CYC = `DSSC_SETTLE_CYC,
    parameter STEPS_PER_TRACK = `DSSC_STEPS_PER_TRACK
)
(
    // Clock and reset
    input wire clk_sys,
    input wire reset,
    // Seek request from the adapter
    input wire seek_req,
    input wire [6:0] seek_track,
    input wire seek_spare_ok,
    // Access request from the adapter
    input wire access_req,
    input wire access_side,
    input wire access_label,
    // Media sensing pin
    input wire single_sided_in,
    // Seek answer
    output reg seek_busy_ff,
    output reg seek_done_ff,
    output reg seek_err_ff,
    output reg [6:0] cur_track_ff,
    // Access answer
    output reg access_ok_ff,
    output reg access_deny_ff,
    output reg head_side_ff,
    output reg single_sided_ff,
    // Stepper windings
    output wire [3:0] winding
);

localparam ST_IDLE = 3'b001;
localparam ST_STEP = 3'b010;
localparam ST_SETTLE = 3'b100;

reg [2:0] state_ff;
reg [2:0] nxt_state;
reg [6:0] target_ff;
reg [6:0] nxt_target;
reg dir_in_ff;
reg nxt_dir_in;
reg [31:0] tmr_ff;
reg [31:0] nxt_tmr;
reg [7:0] stepcnt_ff;
reg [7:0] nxt_stepcnt;
reg [6:0] nxt_cur_track;
reg nxt_busy;
reg nxt_done;
reg nxt_err;
reg step_pulse;
reg [2:0] ss_sync_ff;
reg nxt_access_ok;
reg nxt_access_deny;
reg nxt_head_side;

// Track is a legal seek target: in range, and spares only when substituting
function dssc_track_legal;
    input [6:0] trk;
    input spare_ok;
    begin
        if (trk > `DSSC_LAST_TRACK)
            dssc_track_legal = 1'b0;
        else if ((trk == `DSSC_SPARE_LO || trk == `DSSC_SPARE_HI) && !spare_ok)
            dssc_track_legal = 1'b0;
        else
            dssc_track_legal = 1'b1;
    end
endfunction

dssc_phase_gen u_phase
(
    .clk_sys(clk_sys),
    .reset(reset),
    .step_pulse(step_pulse),
    .step_inward(dir_in_ff),
    .winding_ff(winding)
);

// Media sense pin: three stages, a change is taken when stages two and three agree
always @(posedge clk_sys)
begin
    if (reset)
    begin
        ss_sync_ff <= 3'h0;
        single_sided_ff <= 1'b0;
    end
    else
    begin
        ss_sync_ff <= {ss_sync_ff[1:0], single_sided_in};
        if (ss_sync_ff[1] == ss_sync_ff[2])
            single_sided_ff <= ss_sync_ff[2];
    end
end

always @*
begin
    nxt_state = state_ff;
    nxt_target = target_ff;
    nxt_dir_in = dir_in_ff;
    nxt_tmr = tmr_ff;
    nxt_stepcnt = stepcnt_ff;
    nxt_cur_track = cur_track_ff;
    nxt_busy = seek_busy_ff;
    nxt_done = 1'b0;
    nxt_err = 1'b0;
    step_pulse = 1'b0;
    case (state_ff)
        ST_IDLE:
        begin
            if (seek_req)
            begin
                if (!dssc_track_legal(seek_track, seek_spare_ok))
                begin
                    nxt_err = 1'b1;
                end
                else if (seek_track == cur_track_ff)
                begin
                    // Already on the cylinder: no motion, no settling needed
                    nxt_done = 1'b1;
                end
                else
                begin
                    nxt_target = seek_track;
                    nxt_dir_in = (seek_track > cur_track_ff);
                    nxt_tmr = 32'h0;
                    nxt_stepcnt = 8'h0;
                    nxt_busy = 1'b1;
                    nxt_state = ST_STEP;
                end
            end
        end
        ST_STEP:
        begin
            if (tmr_ff >= STEP_CYC - 1)
            begin
                nxt_tmr = 32'h0;
                step_pulse = 1'b1;
                if (stepcnt_ff == STEPS_PER_TRACK - 1)
                begin
                    // 50 steps of 1.8 degrees make the 90 degrees of one track
                    nxt_stepcnt = 8'h0;
                    if (dir_in_ff)
                        nxt_cur_track = cur_track_ff + 7'h01;
                    else
                        nxt_cur_track = cur_track_ff - 7'h01;
                    if (nxt_cur_track == target_ff)
                        nxt_state = ST_SETTLE;
                end
                else
                begin
                    nxt_stepcnt = stepcnt_ff + 8'h01;
                end
            end
            else
            begin
                nxt_tmr = tmr_ff + 32'h1;
            end
        end
        ST_SETTLE:
        begin
            // Carriage still ringing; done is held back until the full interval ends
            if (tmr_ff >= SETTLE_CYC - 1)
            begin
                nxt_tmr = 32'h0;
                nxt_busy = 1'b0;
                nxt_done = 1'b1;
                nxt_state = ST_IDLE;
            end
            else
            begin
                nxt_tmr = tmr_ff + 32'h1;
            end
        end
        default:
        begin
            nxt_state = ST_IDLE;
            nxt_busy = 1'b0;
        end
    endcase
end

// Access checks: label track, blank side of single-sided media, busy carriage
always @*
begin
    nxt_access_ok = 1'b0;
    nxt_access_deny = 1'b0;
    nxt_head_side = head_side_ff;
    if (access_req)
    begin
        if (seek_busy_ff)
            nxt_access_deny = 1'b1;
        else if (cur_track_ff == `DSSC_LABEL_TRACK && !access_label)
            nxt_access_deny = 1'b1;
        else if (access_side && single_sided_ff)
            nxt_access_deny = 1'b1;
        else
        begin
            // Side select is a head switch only, so the cylinder needs no step
            nxt_access_ok = 1'b1;
            nxt_head_side = access_side;
        end
    end
end

always @(posedge clk_sys)
begin
    if (reset)
    begin
        state_ff <= ST_IDLE;
        target_ff <= `DSSC_LABEL_TRACK;
        dir_in_ff <= 1'b0;
        tmr_ff <= 32'h0;
        stepcnt_ff <= 8'h0;
        cur_track_ff <= `DSSC_LABEL_TRACK;
        seek_busy_ff <= 1'b0;
        seek_done_ff <= 1'b0;
        seek_err_ff <= 1'b0;
        access_ok_ff <= 1'b0;
        access_deny_ff <= 1'b0;
        head_side_ff <= 1'b0;
    end
    else
    begin
        state_ff <= nxt_state;
        target_ff <= nxt_target;
        dir_in_ff <= nxt_dir_in;
        tmr_ff <= nxt_tmr;
        stepcnt_ff <= nxt_stepcnt;
        cur_track_ff <= nxt_cur_track;
        seek_busy_ff <= nxt_busy;
        seek_done_ff <= nxt_done;
        seek_err_ff <= nxt_err;
        access_ok_ff <= nxt_access_ok;
        access_deny_ff <= nxt_access_deny;
        head_side_ff <= nxt_head_side;
    end
end

endmodule // dssc_seek_ctrl

/* File: verif/dssc_props.sv */
module dssc_props
#(
    parameter SETTLE_CYC = 20
)
(
    // Clock and reset
    input wire clk_sys,
    input wire reset,
    // Requests
    input wire seek_req,
    input wire [6:0] seek_track,
    input wire seek_spare_ok,
    input wire access_req,
    input wire access_side,
    input wire access_label,
    // Answers
    input wire seek_busy_ff,
    input wire seek_done_ff,
    input wire seek_err_ff,
    input wire [6:0] cur_track_ff,
    input wire access_ok_ff,
    input wire access_deny_ff,
    input wire head_side_ff,
    input wire single_sided_ff,
    input wire [3:0] winding
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] last_ff;
    logic [15:0] quiet_ff;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Cycles since the windings last changed; saturates so long idles never wrap
    always @(posedge clk_sys)
    begin
        last_ff <= winding;
        if (reset)
            quiet_ff <= 16'(SETTLE_CYC);
        else if (winding != last_ff)
            quiet_ff <= 16'h0;
        else if (quiet_ff != 16'hffff)
            quiet_ff <= quiet_ff + 16'h1;
    end
    sequence s_take;
        seek_req && !seek_busy_ff;
    endsequence
    sequence s_acc;
        access_req && !seek_busy_ff;
    endsequence
    property p_onehot;
        $onehot(winding);
    endproperty
    a_onehot: assert property (p_onehot) else $error("winding not one-hot");
    property p_range;
        s_take ##0 seek_track > 7'h4c |=> seek_err_ff && !seek_busy_ff;
    endproperty
    a_range: assert property (p_range) else $error("track beyond 76 accepted");
    property p_spare;
        s_take ##0 (seek_track == 7'h4b || seek_track == 7'h4c) && !seek_spare_ok |=> seek_err_ff;
    endproperty
    a_spare: assert property (p_spare) else $error("spare track taken");
    property p_label;
        access_req && cur_track_ff == 7'h00 && !access_label |=> access_deny_ff && !access_ok_ff;
    endproperty
    a_label: assert property (p_label) else $error("data access on label track");
    property p_blank;
        access_req && access_side && single_sided_ff |=> access_deny_ff && !access_ok_ff;
    endproperty
    a_blank: assert property (p_blank) else $error("blank side reached");
    property p_cyl;
        s_acc ##0 access_label && !single_sided_ff |=> access_ok_ff && head_side_ff == $past(access_side)
            && $stable(winding);
    endproperty
    a_cyl: assert property (p_cyl) else $error("cylinder side not reached");
    property p_hold;
        !seek_busy_ff ##1 !seek_busy_ff |-> $stable(winding);
    endproperty
    a_hold: assert property (p_hold) else $error("winding moved while idle");
    property p_step;
        $changed(winding) |-> seek_busy_ff;
    endproperty
    a_step: assert property (p_step) else $error("step outside a seek");
    property p_move;
        $changed(cur_track_ff) |-> cur_track_ff - $past(cur_track_ff) == 7'h01
            || $past(cur_track_ff) - cur_track_ff == 7'h01;
    endproperty
    a_move: assert property (p_move) else $error("track jumped");
    property p_settle;
        seek_done_ff |-> quiet_ff >= SETTLE_CYC - 2;
    endproperty
    a_settle: assert property (p_settle) else $error("done before settle");
endmodule // dssc_props

bind dssc_seek_ctrl dssc_props #(.SETTLE_CYC(SETTLE_CYC)) i_props (.*);

/* File: verif/dssc_motor_model.sv */
module dssc_motor_model
(
    // Clock and reset
    input wire clk_sys,
    input wire reset,
    // Winding drive
    input wire [3:0] winding,
    // Rotor state
    output logic signed [15:0] pos_ff,
    output logic bad_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] last_ff;
    logic [1:0] dif;
    function automatic logic [1:0] idx(input logic [3:0] w);
        return w == 4'h1 ? 2'h0 : w == 4'h4 ? 2'h1 : w == 4'h2 ? 2'h2 : 2'h3;
    endfunction
    assign dif = idx(winding) - idx(last_ff);
    always @(posedge clk_sys)
    begin
        last_ff <= winding;
        if (reset)
        begin
            pos_ff <= 16'sh0;
            bad_ff <= 1'b0;
        end
        else
        begin
            // Rotor stays in its detent while the pattern is steady
            if (dif == 2'h1)
                pos_ff <= pos_ff + 16'sh1; // One 1.8 degree step, clockwise is inward
            else if (dif == 2'h3)
                pos_ff <= pos_ff - 16'sh1;
            // Two halves at once or a skipped phase loses the rotor
            if (!$onehot(winding) || dif == 2'h2)
                bad_ff <= 1'b1;
        end
    end
endmodule // dssc_motor_model

/* File: verif/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam STEP = 4, SETTLE = 20, SPT = 2;
    logic clk_sys = 0, reset = 1, seek_req = 0, seek_spare_ok = 0, access_req = 0;
    logic access_side = 0, access_label = 0, single_sided_in = 0;
    logic [6:0] seek_track = 7'h00;
    wire seek_busy_ff, seek_done_ff, seek_err_ff, access_ok_ff, access_deny_ff, head_side_ff, single_sided_ff;
    wire [6:0] cur_track_ff;
    wire [3:0] winding;
    wire signed [15:0] pos_ff;
    wire bad_ff;
    int mismatches = 0, comparisons = 0, cyc = 0, lat;
    logic bsy;
    dssc_seek_ctrl #(.STEP_CYC(STEP), .SETTLE_CYC(SETTLE), .STEPS_PER_TRACK(SPT)) i_dut (.*);
    dssc_motor_model i_motor (.*);
    initial forever #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            mismatches++;
            wrap_up;
        end
    end
    task wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task chk(string n, logic [15:0] e, logic [15:0] g);
        comparisons++;
        if (g !== e)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task tick(int n = 1);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // An edge passes first, so back-to-back calls never drive seek_req twice in one time step
    task seek_start(logic [6:0] t, logic sp);
        tick;
        seek_track = t;
        seek_spare_ok = sp;
        seek_req = 1;
        tick;
        seek_req = 0;
        bsy = seek_busy_ff;
    endtask
    // Returns the cycles from the taking edge to the answer
    task seek_wait;
        lat = 0;
        while (seek_done_ff !== 1'b1 && seek_err_ff !== 1'b1 && lat < 2000)
        begin
            tick;
            lat++;
        end
    endtask
    task seek(logic [6:0] t, logic sp);
        seek_start(t, sp);
        seek_wait;
    endtask
    task moved(int from, int to);
        int n;
        n = to > from ? to - from : from - to;
        seek(to, 1);
        chk("busy", 1, bsy);
        chk("done", 1, seek_done_ff);
        chk("idle", 0, seek_busy_ff);
        chk("track", to, cur_track_ff);
        chk("steps", to * SPT, pos_ff);
        chk("time", 1, lat >= n * SPT * STEP + SETTLE - 1 && lat <= n * SPT * STEP + SETTLE + 3);
        chk("phase", 0, bad_ff);
    endtask
    task acc(logic s, logic lb, logic ok);
        tick;
        access_side = s;
        access_label = lb;
        access_req = 1;
        tick;
        access_req = 0;
        chk("acc_ok", ok, access_ok_ff);
        chk("acc_deny", !ok, access_deny_ff);
    endtask
    task test_travel;
        moved(0, 3);
        moved(3, 1);
        seek(7'h01, 0);
        chk("same_done", 1, seek_done_ff);
        chk("same_lat", 0, lat);
        chk("same_pos", 2, pos_ff);
        $display("test travel ended");
    endtask
    task test_limits;
        seek(7'h4d, 1);
        chk("err_77", 1, seek_err_ff);
        chk("busy_77", 0, bsy);
        seek(7'h4b, 0);
        chk("err_75", 1, seek_err_ff);
        chk("kept", 1, cur_track_ff);
        moved(1, 76);
        moved(76, 0);
        $display("test limits ended");
    endtask
    task test_access;
        acc(0, 0, 0);
        acc(0, 1, 1);
        single_sided_in = 1;
        tick(5);
        chk("sense", 1, single_sided_ff);
        acc(1, 1, 0);
        acc(0, 1, 1);
        single_sided_in = 0;
        tick(5);
        chk("sense_off", 0, single_sided_ff);
        acc(1, 1, 1);
        chk("side", 1, head_side_ff);
        chk("still", 0, pos_ff);
        $display("test access ended");
    endtask
    // An access while the carriage moves is refused; the seek still completes
    task test_busy;
        seek_start(7'h02, 0);
        acc(0, 1, 0);
        chk("moving", 1, seek_busy_ff);
        seek_wait;
        chk("arrived_done", 1, seek_done_ff);
        chk("arrived", 2, cur_track_ff);
        $display("test busy ended");
    endtask
    // Reset in mid-seek drops the carriage state back to track 0 and phase 0
    task test_reset;
        seek_start(7'h05, 0);
        tick(10);
        reset = 1;
        tick(2);
        reset = 0;
        chk("rst_busy", 0, seek_busy_ff);
        chk("rst_track", 0, cur_track_ff);
        chk("rst_wind", 4'h1, winding);
        chk("rst_side", 0, head_side_ff);
        moved(0, 2);
        $display("test reset ended");
    endtask
    initial
    begin
        tick(12);
        reset = 0;
        test_travel;
        test_limits;
        test_access;
        test_busy;
        test_reset;
        wrap_up;
    end
endmodule // tb_top
